// ### logic/sacs_regs.vh
// register offsets, field positions and reset values of the service acknowledge block
`ifndef SACS_REGS_VH
`define SACS_REGS_VH

// =====================================================================
// register byte offsets (one 32-bit word each)
`define SACS_OFS_CAR        8'h00
`define SACS_OFS_RIR        8'h04
`define SACS_OFS_TIR        8'h08
`define SACS_OFS_MIR        8'h0c
`define SACS_OFS_PIR        8'h10
`define SACS_OFS_RVEC       8'h14
`define SACS_OFS_TVEC       8'h18
`define SACS_OFS_MVEC       8'h1c
`define SACS_OFS_LVEC       8'h20
`define SACS_OFS_PVEC       8'h24
`define SACS_OFS_RREQ       8'h28
`define SACS_OFS_TREQ       8'h2c
`define SACS_OFS_MREQ       8'h30
`define SACS_OFS_EOS        8'h34
`define SACS_OFS_MCHG       8'h38
`define SACS_OFS_PCTL       8'h3c
`define SACS_OFS_PSTAT      8'h40
`define SACS_OFS_CSTAT      8'h44
`define SACS_OFS_CTX        8'h48
`define SACS_OFS_CHIPID     8'h4c

// =====================================================================
// field positions
`define SACS_REQ_BIT        7
`define SACS_ACT_BIT        6
`define SACS_CHN_SHIFT      2
`define SACS_PCTL_IEN_BIT   0

// =====================================================================
// source-type codes in the low three vector bits
`define SACS_TYP_RX_GOOD    3'h3
`define SACS_TYP_RX_EXC     3'h7
`define SACS_TYP_TX         3'h2
`define SACS_TYP_MDM        3'h1
`define SACS_TYP_PAR_CHN    3'h4
`define SACS_TYP_PAR_PIPE   3'h5
`define SACS_TYP_PAR_BOTH   3'h6

// =====================================================================
// reset values and context codes
`define SACS_CTX_NONE       3'h0
`define SACS_CTX_RX         3'h1
`define SACS_CTX_TX         3'h2
`define SACS_CTX_MDM        3'h3
`define SACS_CTX_PAR        3'h4
`define SACS_CHIPID_RST     5'h00
`define SACS_PCTL_RST       8'h00

`endif

// ### logic/sacs_stack.v
// context stack memory for saved service environments
`timescale 1ns/100ps
module sacs_stack #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // push and pop
  input  wire             push_i,
  input  wire             pop_i,
  input  wire [WIDTH-1:0] push_data_i,
  // status and top of stack
  output reg  [WIDTH-1:0] top_o,
  output wire             empty_o,
  output wire             full_o
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW:0]      ptr_ff;

  assign empty_o = (ptr_ff == {(AW+1){1'b0}});
  assign full_o  = (ptr_ff == DEPTH[AW:0]);

  // =====================================================================
  // storage
  always @(posedge clk_i) begin
    if (push_i && !full_o) begin
      mem_ff[ptr_ff[AW-1:0]] <= push_data_i;
    end
  end

  // =====================================================================
  // pointer and registered top entry
  always @(posedge clk_i) begin
    if (rst_i) begin
      ptr_ff <= {(AW+1){1'b0}};
      top_o  <= {WIDTH{1'b0}};
    end else if (push_i && !full_o) begin
      ptr_ff <= ptr_ff + 1'b1;
      top_o  <= push_data_i;
    end else if (pop_i && !empty_o) begin
      ptr_ff <= ptr_ff - 1'b1;
      if (ptr_ff >= 2) begin
        top_o <= mem_ff[ptr_ff[AW-1:0] - 2'd2];
      end else begin
        top_o <= {WIDTH{1'b0}};
      end
    end
  end

endmodule

// ### logic/sacs_top.v
// service acknowledge and context switch logic with wishbone register access
`timescale 1ns/100ps
`include "sacs_regs.vh"

module sacs_top #(
  parameter DEPTH = 4
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // hardware service acknowledge strobes
  input  wire        receive_ack_strobe_n_i,
  input  wire        transmit_ack_strobe_n_i,
  input  wire        modem_ack_strobe_n_i,
  input  wire        parallel_ack_strobe_n_i,
  output reg  [7:0]  ack_vector_o,
  output reg         ack_vector_valid_o,
  // serial channel requests (one bit per channel) and modem lines (six per channel)
  input  wire [1:0]  rx_req_i,
  input  wire [1:0]  rx_exc_i,
  input  wire [1:0]  tx_req_i,
  input  wire [1:0]  mdm_req_i,
  input  wire [11:0] mdm_lines_i,
  // parallel channel sources
  input  wire [7:0]  pipeline_cond_i,
  input  wire [7:0]  channel_cond_i,
  // context state
  output wire [2:0]  service_mode_o,
  output wire [1:0]  channel_ptr_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ACK  = 3'b010;
  localparam ST_DONE = 3'b100;

  // =====================================================================
  // state
  reg [2:0]  st_ff;
  reg [1:0]  car_ff;
  reg [2:0]  mode_ff;
  reg [4:0]  chipid_ff;
  reg [7:0]  pctl_ff;
  reg        preq_ff;
  reg [7:0]  pstat_ff;
  reg [7:0]  cstat_ff;
  reg [11:0] mdm_prev_ff;
  reg [11:0] mchg_ff;
  reg [7:0]  rir_ff;
  reg [7:0]  tir_ff;
  reg [7:0]  mir_ff;
  reg        push;
  reg        pop;
  wire [7:0] stk_top;
  wire       stk_empty;

  wire any_ack = ~receive_ack_strobe_n_i | ~transmit_ack_strobe_n_i |
                 ~modem_ack_strobe_n_i | ~parallel_ack_strobe_n_i;
  wire wr  = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire rd  = cyc_i & stb_i & ~we_i & ~ack_o;

  // lowest-numbered requesting channel per source
  wire       rx_any   = |(rx_req_i | rx_exc_i);
  wire [1:0] rx_ch    = (rx_req_i[0] | rx_exc_i[0]) ? 2'd0 : 2'd1;
  wire       tx_any   = |tx_req_i;
  wire [1:0] tx_ch    = tx_req_i[0] ? 2'd0 : 2'd1;
  wire       mdm_any  = |mdm_req_i;
  wire [1:0] mdm_ch   = mdm_req_i[0] ? 2'd0 : 2'd1;

  wire [2:0] rx_typ = rx_exc_i[rx_ch[0]] ? `SACS_TYP_RX_EXC : `SACS_TYP_RX_GOOD;
  wire [7:0] rvec = {chipid_ff, rx_typ};
  wire [7:0] tvec = {chipid_ff, `SACS_TYP_TX};
  wire [7:0] mvec = {chipid_ff, `SACS_TYP_MDM};

  // parallel source-type bits
  wire       p_pipe = |pstat_ff;
  wire       p_chan = |cstat_ff;
  reg  [2:0] p_typ;
  always @* begin
    p_typ = 3'h0;
    if (p_pipe && p_chan) begin
      p_typ = `SACS_TYP_PAR_BOTH;
    end else if (p_pipe) begin
      p_typ = `SACS_TYP_PAR_PIPE;
    end else if (p_chan) begin
      p_typ = `SACS_TYP_PAR_CHN;
    end
  end
  wire [7:0] lvec = {chipid_ff, p_typ};
  wire [7:0] pvec = lvec;

  // interrupt registers: bit 7 request; bit 6 active and channel low in all but PIR, which holds only the request
  wire [7:0] rir_v = {rx_any, 5'h00, rx_ch};
  wire [7:0] tir_v = {tx_any, 5'h00, tx_ch};
  wire [7:0] mir_v = {mdm_any, 5'h00, mdm_ch};
  wire [7:0] pir_v = {preq_ff, 7'h00};

  assign service_mode_o = mode_ff;
  assign channel_ptr_o  = car_ff;

  // =====================================================================
  // context stack
  sacs_stack #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (2)
  ) u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i ({3'h0, mode_ff, car_ff}),
    .top_o       (stk_top),
    .empty_o     (stk_empty),
    .full_o      ()
  );

  // =====================================================================
  // hardware acknowledge cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff              <= ST_IDLE;
      ack_vector_o       <= 8'h00;
      ack_vector_valid_o <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          ack_vector_valid_o <= 1'b0;
          if (any_ack) begin
            st_ff              <= ST_ACK;
            ack_vector_valid_o <= 1'b1;
            if (!receive_ack_strobe_n_i) begin
              ack_vector_o <= rvec;
            end else if (!transmit_ack_strobe_n_i) begin
              ack_vector_o <= tvec;
            end else if (!modem_ack_strobe_n_i) begin
              ack_vector_o <= mvec;
            end else begin
              ack_vector_o <= pvec;
            end
          end
        end
        ST_ACK: begin
          ack_vector_valid_o <= 1'b0;
          st_ff              <= ST_DONE;
        end
        ST_DONE: begin
          if (!any_ack) begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // =====================================================================
  // push on hardware ack, pop on end-of-service
  wire hw_take = (st_ff == ST_IDLE) & any_ack;
  wire eos_wr  = wr & (adr_i == `SACS_OFS_EOS);
  always @* begin
    push = hw_take;
    pop  = eos_wr & ~hw_take & ~stk_empty;
  end

  // =====================================================================
  // context pointer, mode and parallel request
  wire ien_new = dat_i[`SACS_PCTL_IEN_BIT];
  wire pctl_wr = wr & (adr_i == `SACS_OFS_PCTL);
  wire ien_tgl = pctl_wr & (ien_new != pctl_ff[`SACS_PCTL_IEN_BIT]);
  wire p_set   = (p_pipe | p_chan) & ~preq_ff & (mode_ff != `SACS_CTX_PAR);

  always @(posedge clk_i) begin
    if (rst_i) begin
      car_ff  <= 2'd0;
      mode_ff <= `SACS_CTX_NONE;
      preq_ff <= 1'b0;
      pctl_ff <= `SACS_PCTL_RST;
      rir_ff  <= 8'h00;
      tir_ff  <= 8'h00;
      mir_ff  <= 8'h00;
    end else begin
      if (pctl_wr) begin
        pctl_ff <= dat_i[7:0];
      end
      if (hw_take) begin
        if (!receive_ack_strobe_n_i) begin
          car_ff  <= rx_ch;
          mode_ff <= `SACS_CTX_RX;
          rir_ff  <= rir_v | 8'h40;
        end else if (!transmit_ack_strobe_n_i) begin
          car_ff  <= tx_ch;
          mode_ff <= `SACS_CTX_TX;
          tir_ff  <= tir_v | 8'h40;
        end else if (!modem_ack_strobe_n_i) begin
          car_ff  <= mdm_ch;
          mode_ff <= `SACS_CTX_MDM;
          mir_ff  <= mir_v | 8'h40;
        end else begin
          car_ff  <= 2'd0;
          mode_ff <= `SACS_CTX_PAR;
          preq_ff <= 1'b1;
        end
      end else if (pop) begin
        car_ff  <= stk_top[1:0];
        mode_ff <= stk_top[4:2];
        if (mode_ff == `SACS_CTX_PAR) begin
          preq_ff <= 1'b0;
        end
      end else if (wr) begin
        case (adr_i)
          `SACS_OFS_CAR: begin
            car_ff <= dat_i[1:0];
            if (dat_i[1:0] == 2'd0 && preq_ff) begin
              mode_ff <= `SACS_CTX_PAR;
            end else if (rir_v[`SACS_REQ_BIT] && dat_i[1:0] == rx_ch) begin
              mode_ff <= `SACS_CTX_RX;
            end
          end
          `SACS_OFS_RIR, `SACS_OFS_TIR, `SACS_OFS_MIR: begin
            if (!dat_i[`SACS_REQ_BIT] && !dat_i[`SACS_ACT_BIT]) begin
              mode_ff <= `SACS_CTX_NONE;
            end
          end
          `SACS_OFS_PIR: begin
            if (!dat_i[`SACS_REQ_BIT]) begin
              preq_ff <= 1'b0;
              if (mode_ff == `SACS_CTX_PAR) begin
                mode_ff <= `SACS_CTX_NONE;
              end
            end
          end
          `SACS_OFS_PCTL: begin
            if (ien_tgl) begin
              preq_ff <= 1'b0;
              if (mode_ff == `SACS_CTX_PAR) begin
                mode_ff <= `SACS_CTX_NONE;
              end
            end
          end
          default: ;
        endcase
      end else if (p_set) begin
        preq_ff <= 1'b1;
      end
    end
  end

  // =====================================================================
  // chip id, block status and modem change capture
  always @(posedge clk_i) begin
    if (rst_i) begin
      chipid_ff   <= `SACS_CHIPID_RST;
      pstat_ff    <= 8'h00;
      cstat_ff    <= 8'h00;
      mdm_prev_ff <= 12'h000;
      mchg_ff     <= 12'h000;
    end else begin
      if (wr && adr_i == `SACS_OFS_CHIPID) begin
        chipid_ff <= dat_i[4:0];
      end
      // sources set wins over a clearing write (write one to clear)
      pstat_ff <= (wr && adr_i == `SACS_OFS_PSTAT) ?
                  ((pstat_ff & ~dat_i[7:0]) | pipeline_cond_i) :
                  (pstat_ff | pipeline_cond_i);
      cstat_ff <= (wr && adr_i == `SACS_OFS_CSTAT) ?
                  ((cstat_ff & ~dat_i[7:0]) | channel_cond_i) :
                  (cstat_ff | channel_cond_i);
      mdm_prev_ff <= mdm_lines_i;
      mchg_ff <= (wr && adr_i == `SACS_OFS_MCHG) ?
                 ((mchg_ff & ~dat_i[11:0]) | (mdm_lines_i ^ mdm_prev_ff)) :
                 (mchg_ff | (mdm_lines_i ^ mdm_prev_ff));
    end
  end

  // =====================================================================
  // wishbone read mux, one-cycle ack
  wire [5:0] mchg_sel = car_ff[0] ? mchg_ff[11:6] : mchg_ff[5:0];
  reg  [7:0] rdat;
  always @* begin
    rdat = 8'h00;
    case (adr_i)
      `SACS_OFS_CAR:    rdat = {6'h00, car_ff};
      `SACS_OFS_RIR:    rdat = (mode_ff == `SACS_CTX_RX) ? rir_ff : rir_v;
      `SACS_OFS_TIR:    rdat = (mode_ff == `SACS_CTX_TX) ? tir_ff : tir_v;
      `SACS_OFS_MIR:    rdat = (mode_ff == `SACS_CTX_MDM) ? mir_ff : mir_v;
      `SACS_OFS_PIR:    rdat = pir_v;
      `SACS_OFS_RVEC:   rdat = rvec;
      `SACS_OFS_TVEC:   rdat = tvec;
      `SACS_OFS_MVEC:   rdat = mvec;
      `SACS_OFS_LVEC:   rdat = lvec;
      `SACS_OFS_PVEC:   rdat = pvec;
      `SACS_OFS_RREQ:   rdat = {4'h0, car_ff, 2'b00};
      `SACS_OFS_TREQ:   rdat = {4'h0, car_ff, 2'b00};
      `SACS_OFS_MREQ:   rdat = {4'h0, car_ff, 2'b00};
      `SACS_OFS_MCHG:   rdat = {2'b00, mchg_sel};
      `SACS_OFS_PCTL:   rdat = pctl_ff;
      `SACS_OFS_PSTAT:  rdat = pstat_ff;
      `SACS_OFS_CSTAT:  rdat = cstat_ff;
      `SACS_OFS_CTX:    rdat = {3'h0, mode_ff, car_ff};
      `SACS_OFS_CHIPID: rdat = {3'h0, chipid_ff};
      default:          rdat = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h00000000;
    end else begin
      ack_o    <= cyc_i & stb_i & ~ack_o;
      if (rd) begin
        dat_o <= {24'h000000, rdat};
      end
    end
  end

endmodule

// ### test/sacs_chk.sv
// port-level assertions for the service acknowledge block
`timescale 1ns/100ps
module sacs_chk (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // wishbone handshake
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // hardware acknowledge and context
  input wire logic       receive_ack_strobe_n_i,
  input wire logic       transmit_ack_strobe_n_i,
  input wire logic       modem_ack_strobe_n_i,
  input wire logic       parallel_ack_strobe_n_i,
  input wire logic [7:0] ack_vector_o,
  input wire logic       ack_vector_valid_o,
  input wire logic [2:0] service_mode_o,
  input wire logic [1:0] channel_ptr_o
);
  wire [3:0] stb_n = {parallel_ack_strobe_n_i, modem_ack_strobe_n_i,
                      transmit_ack_strobe_n_i, receive_ack_strobe_n_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==================================================================
  // sequences
  sequence s_wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_hw_ack;
    $past(stb_n) == 4'hf && stb_n != 4'hf && service_mode_o == 3'h0;
  endsequence
  // ==================================================================
  // properties
  wb_ack_timely_a: assert property (s_wb_req |=> ack_o)
    else $error("bus request without ack");
  wb_ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("bus ack longer than one cycle");
  hw_vector_timely_a: assert property (s_hw_ack |=> ack_vector_valid_o)
    else $error("strobe without vector");
  hw_vector_cause_a: assert property (ack_vector_valid_o |-> $past(stb_n) != 4'hf)
    else $error("vector without strobe");
  hw_valid_pulse_a: assert property (ack_vector_valid_o |=> !ack_vector_valid_o)
    else $error("vector valid too long");
  hw_vector_hold_a: assert property (!ack_vector_valid_o |-> $stable(ack_vector_o))
    else $error("vector changed without valid");
  rx_context_a: assert property (ack_vector_valid_o && !$past(stb_n[0]) |->
    service_mode_o == 3'h1 && ack_vector_o[1:0] == 2'h3 && ack_vector_o[2:0] != 3'h3 ^
    ack_vector_o[2] == 1'b0) else $error("receive context wrong");
  tx_context_a: assert property (ack_vector_valid_o && $past(stb_n[1:0]) == 2'b01 |->
    service_mode_o == 3'h2 && ack_vector_o[2:0] == 3'h2) else $error("transmit context wrong");
  mdm_context_a: assert property (ack_vector_valid_o && $past(stb_n[2:0]) == 3'b011 |->
    service_mode_o == 3'h3 && ack_vector_o[2:0] == 3'h1) else $error("modem context wrong");
  par_context_a: assert property (ack_vector_valid_o && $past(stb_n) == 4'h7 |->
    service_mode_o == 3'h4 && channel_ptr_o == 2'h0 && ack_vector_o[2:0] inside {3'h4, 3'h5, 3'h6})
    else $error("parallel context wrong");
endmodule
bind sacs_top sacs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .receive_ack_strobe_n_i(receive_ack_strobe_n_i),
  .transmit_ack_strobe_n_i(transmit_ack_strobe_n_i), .modem_ack_strobe_n_i(modem_ack_strobe_n_i),
  .parallel_ack_strobe_n_i(parallel_ack_strobe_n_i), .ack_vector_o(ack_vector_o),
  .ack_vector_valid_o(ack_vector_valid_o), .service_mode_o(service_mode_o),
  .channel_ptr_o(channel_ptr_o));

// ### test/sacs_host.sv
// host model issuing hardware service acknowledge strobes
`timescale 1ns/100ps
module sacs_host (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // commands from the bench
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  // device side
  input  wire logic       vec_valid_i,
  input  wire logic [7:0] vec_i,
  output logic      [3:0] strobe_n_o,
  output logic      [7:0] vec_o,
  output logic            done_o
);
  // strobe held low until the vector arrives, then released whole
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      strobe_n_o <= 4'hf;
    end else if (strobe_n_o != 4'hf) begin
      if (vec_valid_i) begin
        vec_o      <= vec_i;
        strobe_n_o <= 4'hf;
        done_o     <= 1'b1;
      end
    end else if (go_i) begin
      strobe_n_o <= ~(4'h1 << kind_i);
    end
  end
endmodule

// ### test/sacs_top_tb_top.sv
// self-checking bench for the service acknowledge block
`timescale 1ns/100ps
`include "sacs_regs.vh"
module sacs_top_tb_top;
  // ==================================================================
  // signals
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, vld, h_go, h_done;
  logic [7:0]  adr_i, vec, h_vec, pcond, ccond;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  strb_n, sel_i;
  logic [1:0]  rx_req, rx_exc, tx_req, mdm_req, h_kind, ptr;
  logic [11:0] lines;
  logic [2:0]  mode;
  int          err_count, n_compared, cycles;
  // arbitrary chip id so that the vector's upper bits are exercised
  localparam logic [4:0] CID = 5'h15;
  sacs_top #(.DEPTH(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .receive_ack_strobe_n_i(strb_n[0]), .transmit_ack_strobe_n_i(strb_n[1]),
    .modem_ack_strobe_n_i(strb_n[2]), .parallel_ack_strobe_n_i(strb_n[3]),
    .ack_vector_o(vec), .ack_vector_valid_o(vld), .rx_req_i(rx_req), .rx_exc_i(rx_exc),
    .tx_req_i(tx_req), .mdm_req_i(mdm_req), .mdm_lines_i(lines), .pipeline_cond_i(pcond),
    .channel_cond_i(ccond), .service_mode_o(mode), .channel_ptr_o(ptr));
  sacs_host u_host (.clk_i(clk_i), .rst_i(rst_i), .go_i(h_go), .kind_i(h_kind),
    .vec_valid_i(vld), .vec_i(vec), .strobe_n_o(strb_n), .vec_o(h_vec), .done_o(h_done));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ==================================================================
  // shared tasks
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic svc(input logic [1:0] k, input logic [7:0] v, input logic [2:0] m,
                     input logic [1:0] p);
    int n;
    n = 0;
    @(posedge clk_i);
    h_kind <= k;
    h_go   <= 1'b1;
    @(posedge clk_i);
    h_go <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (h_done !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    chk("vector", h_vec, v);
    chk("mode", mode, m);
    chk("pointer", ptr, p);
  endtask
  task automatic eos(input logic [1:0] p);
    wb(1'b1, `SACS_OFS_EOS, 32'h0);
    chk("mode after end", mode, 3'h0);
    chk("pointer after end", ptr, p);
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset;
    rd(`SACS_OFS_PCTL, 32'h0, "control reset");
    rd(`SACS_OFS_CHIPID, 32'h0, "chip id reset");
    wb(1'b1, 8'h50, 32'hff);
    rd(8'h50, 32'h0, "unmapped");
    sel_i <= 4'he;
    wb(1'b1, `SACS_OFS_CHIPID, 32'h1f);
    sel_i <= 4'hf;
    rd(`SACS_OFS_CHIPID, 32'h0, "chip id unselected");
    wb(1'b1, `SACS_OFS_CHIPID, {27'h0, CID});
    rd(`SACS_OFS_CHIPID, {27'h0, CID}, "chip id");
    $display("test reset done");
  endtask
  task automatic t_rx;
    rx_req <= 2'b10;
    svc(2'd0, {CID, 3'h3}, 3'h1, 2'd1);
    rd(`SACS_OFS_RREQ, 32'h4, "rx requester");
    rd(`SACS_OFS_RIR, 32'hc1, "rx interrupt active");
    rx_req <= 2'b00;
    eos(2'd0);
    rx_exc <= 2'b01;
    svc(2'd0, {CID, 3'h7}, 3'h1, 2'd0);
    rx_exc <= 2'b00;
    eos(2'd0);
    $display("test rx done");
  endtask
  task automatic t_tx_mdm;
    tx_req <= 2'b10;
    svc(2'd1, {CID, 3'h2}, 3'h2, 2'd1);
    rd(`SACS_OFS_TREQ, 32'h4, "tx requester");
    tx_req <= 2'b00;
    eos(2'd0);
    lines   <= 12'h005;
    mdm_req <= 2'b01;
    svc(2'd2, {CID, 3'h1}, 3'h3, 2'd0);
    rd(`SACS_OFS_MCHG, 32'h5, "modem change");
    mdm_req <= 2'b00;
    eos(2'd0);
    $display("test tx modem done");
  endtask
  task automatic t_par;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `SACS_OFS_CAR, 32'h1);
      pcond <= (i != 1) ? 8'h01 : 8'h00;
      ccond <= (i != 0) ? 8'h02 : 8'h00;
      @(posedge clk_i);
      pcond <= 8'h00;
      ccond <= 8'h00;
      rd(`SACS_OFS_PSTAT, (i != 1) ? 32'h1 : 32'h0, "pipe status");
      rd(`SACS_OFS_CSTAT, (i != 0) ? 32'h2 : 32'h0, "chan status");
      wb(1'b0, `SACS_OFS_PIR, 32'h0);
      chk("parallel register", q, 32'h80);
      svc(2'd3, {CID, ((i == 0) ? 3'h5 : ((i == 1) ? 3'h4 : 3'h6))}, 3'h4, 2'd0);
      eos(2'd1);
      wb(1'b1, `SACS_OFS_PSTAT, 32'hff);
      wb(1'b1, `SACS_OFS_CSTAT, 32'hff);
    end
    $display("test parallel done");
  endtask
  task automatic t_sw;
    rx_req <= 2'b10;
    wb(1'b1, `SACS_OFS_CAR, 32'h81);
    chk("sw rx mode", mode, 3'h1);
    wb(1'b1, `SACS_OFS_RIR, 32'h81 & 32'h3f);
    chk("sw rx end", mode, 3'h0);
    rx_req <= 2'b00;
    for (int i = 0; i < 2; i++) begin
      pcond <= (i == 0) ? 8'h01 : 8'h00;
      ccond <= (i == 1) ? 8'h02 : 8'h00;
      @(posedge clk_i);
      pcond <= 8'h00;
      ccond <= 8'h00;
      wb(1'b1, `SACS_OFS_CAR, 32'h0);
      chk("sw par mode", mode, 3'h4);
      chk("sw par pointer", ptr, 2'd0);
      rd(`SACS_OFS_LVEC, {24'h0, CID, ((i == 0) ? 3'h5 : 3'h4)}, "local vector");
      wb(1'b1, (i == 0) ? `SACS_OFS_PSTAT : `SACS_OFS_CSTAT, 32'hff);
      wb(1'b1, (i == 0) ? `SACS_OFS_PIR : `SACS_OFS_PCTL, (i == 0) ? 32'h0 : 32'h1);
      chk("sw par end", mode, 3'h0);
      rd(`SACS_OFS_PIR, 32'h0, "request cleared");
    end
    $display("test software service done");
  endtask
  // ==================================================================
  // main sequence and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, h_go} = 5'h10;
    {adr_i, dat_i, h_kind, rx_req, rx_exc, tx_req, mdm_req} = '0;
    {lines, pcond, ccond} = '0;
    sel_i = 4'hf;
    {err_count, n_compared, cycles} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("mode at reset", mode, 3'h0);
    t_reset;
    t_rx;
    t_tx_mdm;
    t_par;
    t_sw;
    finish_test;
  end
endmodule
